// >>> sual_cfg.svh
// Constants for the servo utility alarm log and jog sequencer
// Notes on behaviour
// - Keep ten newest alarms with code, stamp
// - Stamp counts power-on time in 100 ms
// - Stamp runs thirteen years without wrapping
// - Same code repeats stored only after hour
// - Empty slot reads as dedicated empty pattern
// - Log survives alarm reset; erase function or APB erase clears it
// - Menu lists functions, data enters, menu returns while power is off
// - Jog speed 0..10000, default 50, immediate
// - Data toggles cursor between field and value
// - Servo key in blocked state enables power
// - Motion only while up or down held
// - Servo key while running removes power
// - Direction zero: forward counts scale up
// - Overtravel stop disabled during jog
// - Origin search seeks index, then clamps
// - Limit inputs ignored during origin search
// - Origin search speed fixed 15 mm/s
// - At index stop and show completion
// - Direction one reverses key to count mapping
`ifndef SUAL_CFG_SVH
`define SUAL_CFG_SVH
`define SUAL_LOG_DEPTH       10
`define SUAL_CLK_HZ          50000000
`define SUAL_TICK_MS         100
`define SUAL_TICK_CYCLES     ((`SUAL_CLK_HZ / 1000) * `SUAL_TICK_MS)
`define SUAL_HOUR_TICKS      32'h0000_8CA0
`define SUAL_JOG_MAX         14'h2710
`define SUAL_JOG_DEFAULT     14'h0032
`define SUAL_SEEK_SPEED      14'h000F
`define SUAL_EMPTY_CODE      12'hFFF
`define SUAL_FN_VIEW         2'h0
`define SUAL_FN_JOG          2'h1
`define SUAL_FN_SEEK         2'h2
`define SUAL_FN_ERASE        2'h3
`endif

// >>> sual_log.sv
// Ten-entry alarm history, newest first
`timescale 1ns/1ps
`include "sual_cfg.svh"
module sual_log
    import sual_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Store and erase
    input  wire logic        store,
    input  wire logic        erase,
    input  sual_entry_type   new_entry,
    // View
    input  wire logic [3:0]  index,
    output sual_entry_type   view,
    output sual_entry_type   newest
);
    sual_entry_type mem_q [`SUAL_LOG_DEPTH];
    localparam sual_entry_type EMPTY = '{code: `SUAL_EMPTY_CODE, stamp: '0};

    genvar i;
    generate
        for (i = 0; i < `SUAL_LOG_DEPTH; i++) begin : g_slot
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    mem_q[i] <= EMPTY;
                end else if (erase) begin
                    mem_q[i] <= EMPTY;
                end else if (store) begin
                    if (i == 0) begin
                        mem_q[i] <= new_entry;
                    end else begin
                        mem_q[i] <= mem_q[(i > 0) ? i - 1 : 0];
                    end
                end
            end
        end
    endgenerate

    always_comb begin
        if (index < 4'(`SUAL_LOG_DEPTH)) begin
            view = mem_q[index];
        end else begin
            view = EMPTY;
        end
    end
    assign newest = mem_q[0];

    chk_log_shift: assert property (@(posedge pclk) disable iff (!presetn)
        store && !erase |=> mem_q[1] == $past(mem_q[0]))
        else $error("log did not shift");
endmodule

// >>> sual_panel.sv
// Operator keypad model driving the sequencer's key pins
`timescale 1ns/1ps
module sual_panel
    import sual_pkg::*;
(
    // Clock
    input  wire logic        pclk,
    // Key pins
    output sual_keys_type    keys
);
    // ------------------------------------------------------------
    // Key levels
    // ------------------------------------------------------------
    sual_keys_type k_q = '0;
    assign keys = k_q;

    // Held long enough to clear the two-flop synchroniser
    task automatic hold(input int k, input logic v);
        @(posedge pclk);
        k_q[k] <= v;
        repeat (8) @(posedge pclk);
    endtask

    // A press is a full make then break, never a glitch
    task automatic press(input int k);
        hold(k, 1'b1);
        hold(k, 1'b0);
    endtask
endmodule

// >>> sual_pkg.sv
// Types shared by the servo utility sequencer
package sual_pkg;
    typedef struct packed {
        logic [11:0] code;
        logic [31:0] stamp;
    } sual_entry_type;

    typedef struct packed {
        logic menu;
        logic up;
        logic down;
        logic data;
        logic servo;
    } sual_keys_type;

    typedef struct packed {
        logic        power_on;
        logic        fwd;
        logic        rev;
        logic [13:0] speed;
        logic        limits_on;
    } sual_drive_type;
endpackage

// >>> sual_stamp.sv
// Power-on time stamp counter
`timescale 1ns/1ps
`include "sual_cfg.svh"
module sual_stamp
    import sual_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Power state
    input  wire logic        powered,
    // Count
    output logic [31:0]      stamp
);
    localparam int TICKS = `SUAL_TICK_CYCLES;
    logic [22:0] div_q;
    logic [31:0] stamp_q;

    // 32 bits of 100 ms ticks last about 13.6 years before wrapping
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q   <= '0;
            stamp_q <= '0;
        end else if (powered) begin
            if (div_q == 23'(TICKS - 1)) begin
                div_q   <= '0;
                stamp_q <= stamp_q + 32'h1;
            end else begin
                div_q <= div_q + 23'h1;
            end
        end
    end
    assign stamp = stamp_q;

    chk_stamp_step: assert property (@(posedge pclk) disable iff (!presetn)
        stamp_q != $past(stamp_q) |-> stamp_q == $past(stamp_q) + 32'h1)
        else $error("stamp moved by other than one");
endmodule

// >>> sual_top.sv
// Utility sequencer: alarm history, jog and origin search
`timescale 1ns/1ps
`include "sual_cfg.svh"
module sual_top
    import sual_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Keypad pins
    input  wire logic        key_menu,
    input  wire logic        key_up,
    input  wire logic        key_down,
    input  wire logic        key_data,
    input  wire logic        key_servo,
    // Drive status pins
    input  wire logic        main_power,
    input  wire logic        control_power,
    input  wire logic        index_pulse,
    input  wire logic        forward_limit_input,
    input  wire logic        reverse_limit_input,
    // Alarm event from drive logic
    input  wire logic        alarm_valid,
    input  wire logic [11:0] alarm_code,
    // Drive command
    output logic             motor_power,
    output logic             drive_fwd,
    output logic             drive_rev,
    output logic [13:0]      drive_speed,
    output logic             limits_enabled,
    output logic             seek_complete,
    output logic             run_status
);
    // --------------------------------------------------------------
    // Register map
    // --------------------------------------------------------------
    localparam logic [11:0] A_STATUS = 12'h000;
    localparam logic [11:0] A_SPEED  = 12'h004;
    localparam logic [11:0] A_DIR    = 12'h008;
    localparam logic [11:0] A_INDEX  = 12'h00C;
    localparam logic [11:0] A_CODE   = 12'h010;
    localparam logic [11:0] A_STAMP  = 12'h014;
    localparam logic [11:0] A_NOW    = 12'h018;

    typedef enum logic [4:0] {
        ST_MENU = 5'b00001,
        ST_VIEW = 5'b00010,
        ST_JOG  = 5'b00100,
        ST_SEEK = 5'b01000,
        ST_DONE = 5'b10000
    } sual_state_type;

    // --------------------------------------------------------------
    // Pin synchronisers
    // --------------------------------------------------------------
    logic [9:0] sync1_q;
    logic [9:0] sync2_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {key_menu, key_up, key_down, key_data, key_servo,
                        main_power, control_power, index_pulse,
                        forward_limit_input, reverse_limit_input};
            sync2_q <= sync1_q;
        end
    end
    sual_keys_type keys;
    logic          main_on;
    logic          ctrl_on;
    logic          index_s;
    assign keys    = sync2_q[9:5];
    assign main_on = sync2_q[4];
    assign ctrl_on = sync2_q[3];
    assign index_s = sync2_q[2];

    sual_keys_type keys_prev_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            keys_prev_q <= '0;
        end else begin
            keys_prev_q <= keys;
        end
    end
    sual_keys_type press;
    assign press = keys & ~keys_prev_q;

    // --------------------------------------------------------------
    // Alarm log and stamp
    // --------------------------------------------------------------
    logic [31:0]    now;
    sual_entry_type view_entry;
    sual_entry_type newest;
    logic [3:0]     view_idx_q;
    logic           store;
    logic           erase;

    sual_stamp u_stamp (
        .pclk    (pclk),
        .presetn (presetn),
        .powered (main_on && ctrl_on),
        .stamp   (now)
    );

    // Repeat of newest code within an hour is dropped
    assign store = alarm_valid &&
        (newest.code != alarm_code ||
         now - newest.stamp > `SUAL_HOUR_TICKS);

    sual_log u_log (
        .pclk      (pclk),
        .presetn   (presetn),
        .store     (store),
        .erase     (erase),
        .new_entry ('{code: alarm_code, stamp: now}),
        .index     (view_idx_q),
        .view      (view_entry),
        .newest    (newest)
    );

    // --------------------------------------------------------------
    // Menu and function sequencer
    // --------------------------------------------------------------
    sual_state_type state_q;
    logic [1:0]     fn_sel_q;
    logic           editing_q;
    logic           power_q;
    logic [13:0]    speed_q;
    logic [13:0]    edit_q;
    logic           dir_q;
    logic           erase_req_q;
    logic           apb_speed_wr;
    logic           apb_erase_wr;

    assign erase = erase_req_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_MENU;
        end else begin
            unique case (state_q)
                ST_MENU: begin
                    if (press.data) begin
                        unique case (fn_sel_q)
                            `SUAL_FN_VIEW: state_q <= ST_VIEW;
                            `SUAL_FN_JOG:  state_q <= ST_JOG;
                            `SUAL_FN_SEEK: state_q <= ST_SEEK;
                            `SUAL_FN_ERASE: state_q <= ST_MENU;
                        endcase
                    end
                end
                ST_VIEW, ST_JOG, ST_SEEK, ST_DONE: begin
                    if (press.menu && !power_q) begin
                        state_q <= ST_MENU;
                    end else if (state_q == ST_SEEK && power_q && index_s) begin
                        state_q <= ST_DONE;
                    end else if (state_q == ST_DONE && press.servo) begin
                        state_q <= ST_SEEK;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fn_sel_q <= `SUAL_FN_VIEW;
        end else if (state_q == ST_MENU) begin
            if (press.up) begin
                fn_sel_q <= fn_sel_q + 2'h1;
            end else if (press.down) begin
                fn_sel_q <= fn_sel_q - 2'h1;
            end
        end
    end

    // Erase from keypad: data on erase entry, or APB
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            erase_req_q <= 1'b0;
        end else begin
            erase_req_q <= apb_erase_wr ||
                (state_q == ST_MENU && press.data &&
                 fn_sel_q == `SUAL_FN_ERASE);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            view_idx_q <= '0;
        end else if (state_q != ST_VIEW) begin
            view_idx_q <= '0;
        end else if (press.down && view_idx_q < 4'(`SUAL_LOG_DEPTH - 1)) begin
            view_idx_q <= view_idx_q + 4'h1;
        end else if (press.up && view_idx_q != 4'h0) begin
            view_idx_q <= view_idx_q - 4'h1;
        end
    end

    // Cursor toggle; up/down edit the value while in the value field
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            editing_q <= 1'b0;
            edit_q    <= `SUAL_JOG_DEFAULT;
        end else if (state_q != ST_JOG || power_q) begin
            editing_q <= 1'b0;
            edit_q    <= speed_q;
        end else if (press.data) begin
            editing_q <= !editing_q;
        end else if (!editing_q) begin
            edit_q <= speed_q;
        end else if (editing_q && press.up && edit_q < `SUAL_JOG_MAX) begin
            edit_q <= edit_q + 14'h1;
        end else if (editing_q && press.down && edit_q != 14'h0) begin
            edit_q <= edit_q - 14'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            speed_q <= `SUAL_JOG_DEFAULT;
        end else if (state_q == ST_JOG && editing_q && press.data) begin
            speed_q <= edit_q;
        end else if (apb_speed_wr && pwdata[13:0] <= `SUAL_JOG_MAX) begin
            speed_q <= pwdata[13:0];
        end
    end

    // Servo key toggles power only inside jog or search screens
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_q <= 1'b0;
        end else if (state_q == ST_MENU || state_q == ST_VIEW) begin
            power_q <= 1'b0;
        end else if (press.servo && !editing_q) begin
            power_q <= !power_q;
        end
    end

    // --------------------------------------------------------------
    // Drive outputs
    // --------------------------------------------------------------
    logic moving;
    logic fwd_key;
    logic rev_key;
    assign moving = power_q && !editing_q &&
                    (state_q == ST_JOG || state_q == ST_SEEK);
    assign fwd_key = moving && keys.up && !keys.down;
    assign rev_key = moving && keys.down && !keys.up;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            motor_power    <= 1'b0;
            drive_fwd      <= 1'b0;
            drive_rev      <= 1'b0;
            drive_speed    <= '0;
            limits_enabled <= 1'b1;
            seek_complete  <= 1'b0;
            run_status     <= 1'b0;
        end else begin
            motor_power <= power_q;
            // Drive command is scale direction: up count means fwd
            drive_fwd   <= dir_q ? rev_key : fwd_key;
            drive_rev   <= dir_q ? fwd_key : rev_key;
            drive_speed <= (state_q == ST_JOG) ? speed_q
                                               : `SUAL_SEEK_SPEED;
            limits_enabled <= !(state_q == ST_JOG ||
                                state_q == ST_SEEK ||
                                state_q == ST_DONE);
            seek_complete <= state_q == ST_DONE;
            run_status    <= power_q;
        end
    end

    // --------------------------------------------------------------
    // APB slave, zero wait
    // --------------------------------------------------------------
    logic wr_en;
    assign wr_en        = psel && penable && pwrite;
    assign apb_speed_wr = wr_en && paddr == A_SPEED;
    assign apb_erase_wr = wr_en && paddr == A_STATUS && pwdata[0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_q <= 1'b0;
        end else if (wr_en && paddr == A_DIR) begin
            dir_q <= pwdata[0];
        end
    end

    logic [31:0] rd_d;
    logic        err_d;
    always_comb begin
        err_d = 1'b0;
        unique case (paddr)
            A_STATUS: rd_d = {24'h0, state_q, seek_complete,
                              power_q, editing_q};
            A_SPEED:  rd_d = {18'h0, speed_q};
            A_DIR:    rd_d = {31'h0, dir_q};
            A_INDEX:  rd_d = {28'h0, view_idx_q};
            A_CODE:   rd_d = {20'h0, view_entry.code};
            A_STAMP:  rd_d = view_entry.stamp;
            A_NOW:    rd_d = now;
            default: begin
                rd_d  = 32'h0;
                err_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && err_d;
            if (psel && !penable) begin
                prdata <= rd_d;
            end
        end
    end

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    chk_jog_speed_used: assert property (@(posedge pclk)
        disable iff (!presetn)
        state_q == ST_JOG |=> drive_speed == $past(speed_q))
        else $error("jog speed not applied");
    chk_seek_speed: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ST_SEEK |=> drive_speed == `SUAL_SEEK_SPEED)
        else $error("search speed wrong");
    chk_limits_off: assert property (@(posedge pclk) disable iff (!presetn)
        state_q inside {ST_JOG, ST_SEEK} |=> !limits_enabled)
        else $error("limits active in jog or search");
    chk_done_stops: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ST_DONE |=> !drive_fwd && !drive_rev)
        else $error("motion after completion");
    chk_dir_normal: assert property (@(posedge pclk) disable iff (!presetn)
        fwd_key && !dir_q |=> drive_fwd && !drive_rev)
        else $error("direction zero mapping");
    chk_dir_swap: assert property (@(posedge pclk) disable iff (!presetn)
        fwd_key && dir_q |=> drive_rev && !drive_fwd)
        else $error("direction one mapping");
    chk_no_key_stop: assert property (@(posedge pclk) disable iff (!presetn)
        !keys.up && !keys.down |=> !drive_fwd && !drive_rev)
        else $error("moving without key");
    chk_speed_range: assert property (@(posedge pclk) disable iff (!presetn)
        speed_q <= `SUAL_JOG_MAX)
        else $error("jog speed out of range");
    chk_servo_toggle: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ST_JOG && press.servo && !editing_q && !press.menu
        |=> ##1 motor_power != $past(motor_power, 2))
        else $error("servo key did not toggle power");
    cov_jog_run: cover property (@(posedge pclk) disable iff (!presetn)
        state_q == ST_JOG && drive_fwd);
    cov_seek_done: cover property (@(posedge pclk) disable iff (!presetn)
        state_q == ST_SEEK ##1 state_q == ST_DONE);
    cov_log_store: cover property (@(posedge pclk) disable iff (!presetn)
        store);
endmodule

// >>> test_servo_utility_alarm_log_jog.sv
// Self-checking bench for the utility sequencer
`timescale 1ns/1ps
module test_servo_utility_alarm_log_jog;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int KM = 4, KU = 3, KD = 2, KT = 1, KS = 0;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0;
    logic        pwrite = 0, pready, pslverr, er;
    logic [11:0] paddr = 12'h000, alarm_code = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        main_power = 1, control_power = 1, index_pulse = 0;
    logic        flim = 0, alarm_valid = 0;
    logic        motor_power, drive_fwd, drive_rev;
    logic        limits_enabled, seek_complete, run_status;
    logic [13:0] drive_speed;
    int          mismatches = 0, num_checks = 0;
    sual_pkg::sual_keys_type keys;
    typedef struct packed {
        logic w; logic [11:0] a; logic [31:0] d, e; logic err;
    } sual_row_type;
    sual_row_type rows [11] = '{
        '{1'h1, 12'h004, 32'h2710, 32'h0, 1'h0},
        '{1'h0, 12'h004, 32'h0, 32'h2710, 1'h0},
        '{1'h1, 12'h004, 32'h2711, 32'h0, 1'h0},
        '{1'h0, 12'h004, 32'h0, 32'h2710, 1'h0},
        '{1'h1, 12'h004, 32'h0, 32'h0, 1'h0},
        '{1'h0, 12'h004, 32'h0, 32'h0, 1'h0},
        '{1'h0, 12'h100, 32'h0, 32'h0, 1'h1},
        '{1'h1, 12'h100, 32'h5, 32'h0, 1'h1},
        '{1'h1, 12'h008, 32'h1, 32'h0, 1'h0},
        '{1'h0, 12'h008, 32'h0, 32'h1, 1'h0},
        '{1'h1, 12'h008, 32'h0, 32'h0, 1'h0}};

    always #10 pclk = ~pclk;

    sual_panel u_panel (.pclk(pclk), .keys(keys));

    sual_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .key_menu(keys.menu), .key_up(keys.up),
        .key_down(keys.down), .key_data(keys.data),
        .key_servo(keys.servo), .main_power(main_power),
        .control_power(control_power), .index_pulse(index_pulse),
        .forward_limit_input(flim), .reverse_limit_input(1'b0),
        .alarm_valid(alarm_valid), .alarm_code(alarm_code),
        .motor_power(motor_power), .drive_fwd(drive_fwd),
        .drive_rev(drive_rev), .drive_speed(drive_speed),
        .limits_enabled(limits_enabled),
        .seek_complete(seek_complete), .run_status(run_status));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %0t reg got %h exp %h", $time, g, e);
        end
    endtask

    task automatic chk_pin(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %0t pin got %h exp %h", $time, g, e);
        end
    endtask

    // Waits on pready with a bound, never on a fixed count
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) mismatches++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rreg(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk_reg(rd, e);
    endtask

    task automatic alarm(input logic [11:0] c);
        @(posedge pclk);
        alarm_valid <= 1'b1;
        alarm_code <= c;
        @(posedge pclk);
        alarm_valid <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge pclk);
        mismatches++;
        end_of_test;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk_pin({limits_enabled, motor_power}, 16'h2);
        rreg(12'h004, 32'h32);
        rreg(12'h010, 32'hFFF);
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk_reg(rd, rows[i].e);
            chk_pin(er, rows[i].err);
        end
        // Both supplies high from the start, as the operator must
        alarm(12'h123);
        alarm(12'h123);
        alarm(12'h456);
        rreg(12'h010, 32'h456);
        rreg(12'h014, 32'h0);
        rreg(12'h018, 32'h0);
        u_panel.press(KM);
        rreg(12'h000, 32'h08);
        u_panel.press(KT);
        rreg(12'h000, 32'h10);
        u_panel.press(KD);
        rreg(12'h00C, 32'h1);
        rreg(12'h010, 32'h123);
        main_power <= 1'b0;
        repeat (4) @(posedge pclk);
        rreg(12'h010, 32'h123);
        main_power <= 1'b1;
        u_panel.press(KD);
        rreg(12'h010, 32'hFFF);
        apb(1'b1, 12'h000, 32'h1);
        u_panel.press(KU);
        rreg(12'h010, 32'hFFF);
        // Keypad erase entry, then on to jog
        alarm(12'h789);
        u_panel.press(KM);
        rreg(12'h010, 32'h789);
        u_panel.press(KD);
        u_panel.press(KT);
        rreg(12'h010, 32'hFFF);
        // Jog: limits off even before power is on
        u_panel.press(KU);
        u_panel.press(KU);
        u_panel.press(KT);
        rreg(12'h000, 32'h20);
        chk_pin(limits_enabled, 16'h0);
        apb(1'b1, 12'h004, 32'h3E8);
        u_panel.press(KT);
        u_panel.press(KU);
        rreg(12'h000, 32'h21);
        u_panel.press(KT);
        rreg(12'h004, 32'h3E9);
        u_panel.press(KS);
        chk_pin({motor_power, run_status}, 16'h3);
        u_panel.hold(KU, 1'b1);
        chk_pin({drive_fwd, drive_rev, drive_speed}, 16'h83E9);
        apb(1'b1, 12'h004, 32'h7D0);
        repeat (2) @(posedge pclk);
        chk_pin(drive_speed, 16'h7D0);
        apb(1'b1, 12'h008, 32'h1);
        repeat (2) @(posedge pclk);
        chk_pin({drive_fwd, drive_rev}, 16'h1);
        u_panel.hold(KU, 1'b0);
        chk_pin({drive_fwd, drive_rev}, 16'h0);
        u_panel.hold(KD, 1'b1);
        chk_pin({drive_fwd, drive_rev}, 16'h2);
        u_panel.hold(KD, 1'b0);
        apb(1'b1, 12'h008, 32'h0);
        u_panel.press(KS);
        chk_pin({motor_power, run_status}, 16'h0);
        // Origin search with a limit asserted on the way
        u_panel.press(KM);
        u_panel.press(KU);
        u_panel.press(KT);
        u_panel.press(KS);
        rreg(12'h000, 32'h42);
        flim <= 1'b1;
        u_panel.hold(KU, 1'b1);
        chk_pin({drive_fwd, drive_speed}, 16'h400F);
        index_pulse <= 1'b1;
        repeat (8) @(posedge pclk);
        chk_pin({drive_fwd, seek_complete}, 16'h1);
        rreg(12'h000, 32'h86);
        u_panel.hold(KU, 1'b0);
        u_panel.press(KS);
        chk_pin(motor_power, 16'h0);
        end_of_test;
    end
endmodule
